/* rtl/ssp_pkg.sv */
// constants, types and behaviour summary for the serial memory slave
// Behaviour
// - select low makes device active; select high means standby with output released
// - a store already under way completes before standby is entered
// - instruction, address and data bits are captured on rising serial clock
// - serial output changes only after a falling serial clock edge
// - first bit is taken on first rising clock after select falls
// - low pause freezes transfer while keeping partial sequence state
// - pause starts at once, whether the clock is low or high
// - during pause output released, serial input and clock ignored
// - pause low always releases the serial output, whatever the clock does
// - after pause the command resumes at exactly the frozen bit
// - each command shifts into an eight-bit instruction register first
// - all words travel most significant bit first, both directions
// - decode memory read 03h and status read 05h opcodes
// - decode memory write 02h and status write 01h opcodes
// - read takes 16-bit address, top three ignored, then shifts stored byte out
// - page mode steps address within 32-word page, wrapping to word zero
// - burst mode steps through whole array, wrapping 1fffh to 0000h
// - page and burst reads end when select rises; word and status reads stop after one byte
// - writes framed like reads; each byte overwrites memory with same stepping
// - status write loads status register whose mode field steers accesses
// - after power-up the device sits in standby until select falls
package ssp_pkg;
   localparam int          ADDR_W     = 13;
   localparam int          MEM_WORDS  = 8192;
   localparam int          PAGE_W     = 5;
   localparam logic [3:0]  ADDR_LAST  = 4'hf;
   localparam logic [2:0]  BYTE_LAST  = 3'h7;
   localparam logic [7:0]  OP_READ    = 8'h03;
   localparam logic [7:0]  OP_WRITE   = 8'h02;
   localparam logic [7:0]  OP_STAT_RD = 8'h05;
   localparam logic [7:0]  OP_STAT_WR = 8'h01;
   localparam int          MODE_LSB   = 6;
   localparam int          TYPE_BIT   = 1;
   localparam int          OPT_BIT    = 0;
   localparam logic [1:0]  MODE_WORD  = 2'h0;
   localparam logic [1:0]  MODE_BURST = 2'h1;
   localparam logic [1:0]  MODE_PAGE  = 2'h2;
   localparam logic [7:0]  STAT_RST   = 8'h02;
   localparam int          SYNC_SEL   = 0;
   localparam int          SYNC_STORE = 1;
   localparam int          SYNC_STAT  = 2;
   localparam int          SYNC_W     = 3;

   typedef enum logic [2:0] {
      ST_CMD, ST_ADDR, ST_RDATA, ST_WDATA, ST_SRD, ST_SWR, ST_DONE
   } ssp_state_t;
endpackage

/* rtl/ssp_cdc_if.sv */
// crossing signals from the serial clock side to the system clock side
interface ssp_cdc_if;
   logic       sel;
   logic       store_tgl;
   logic       stat_tgl;
   logic [7:0] status;
   modport link (output sel, store_tgl, stat_tgl, status);
   modport sys  (input  sel, store_tgl, stat_tgl, status);
endinterface

/* rtl/ssp_sync.sv */
// two-flop level synchroniser into the system clock
module ssp_sync #(
   parameter int W = 1
) (
   input  wire logic         clock_i,
   input  wire logic         arst_n_i,
   input  wire logic         ce_i,
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] meta, next_meta, next_q;

   always_comb begin
      next_meta = meta;
      next_q    = q_o;
      if (ce_i) begin
         next_meta = d_i;
         next_q    = meta;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta <= '0;
         q_o  <= '0;
      end else begin
         meta <= next_meta;
         q_o  <= next_q;
      end
   end
endmodule

/* rtl/ssp_sys_side.sv */
// system clock view: selection, standby, store events and current mode
module ssp_sys_side (
   input  wire logic                      clock_i,
   input  wire logic                      arst_n_i,
   input  wire logic                      ce_i,
   input  wire logic [ssp_pkg::SYNC_W-1:0] synced_i,
   ssp_cdc_if.sys                         cdc,
   output logic                           selected_o,
   output logic                           standby_o,
   output logic                           store_pulse_o,
   output logic      [1:0]                mode_o
);
   logic       store_seen, next_store_seen, stat_seen, next_stat_seen;
   logic       next_selected, next_standby, next_store_pulse;
   logic [1:0] next_mode;

   always_comb begin
      next_store_seen  = store_seen;
      next_stat_seen   = stat_seen;
      next_selected    = selected_o;
      next_standby     = standby_o;
      next_store_pulse = store_pulse_o;
      next_mode        = mode_o;
      if (ce_i) begin
         next_selected    = synced_i[ssp_pkg::SYNC_SEL];
         next_store_seen  = synced_i[ssp_pkg::SYNC_STORE];
         next_store_pulse = synced_i[ssp_pkg::SYNC_STORE] ^ store_seen;
         // standby only once no store event is still in flight
         next_standby     = !synced_i[ssp_pkg::SYNC_SEL] &&
                            (synced_i[ssp_pkg::SYNC_STORE] == store_seen);
         next_stat_seen   = synced_i[ssp_pkg::SYNC_STAT];
         // status word is stable for many serial clocks after its toggle
         if (synced_i[ssp_pkg::SYNC_STAT] != stat_seen) begin
            next_mode = cdc.status[ssp_pkg::MODE_LSB +: 2];
         end
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         store_seen    <= 1'b0;
         stat_seen     <= 1'b0;
         selected_o    <= 1'b0;
         standby_o     <= 1'b1;
         store_pulse_o <= 1'b0;
         mode_o        <= ssp_pkg::MODE_WORD;
      end else begin
         store_seen    <= next_store_seen;
         stat_seen     <= next_stat_seen;
         selected_o    <= next_selected;
         standby_o     <= next_standby;
         store_pulse_o <= next_store_pulse;
         mode_o        <= next_mode;
      end
   end
endmodule

/* rtl/ssp_top.sv */
// serial memory slave: serial engine, 8k x 8 array and system-side view
module ssp_top (
   input  wire logic       clock_i,
   input  wire logic       arst_n_i,
   input  wire logic       ce_i,
   input  wire logic       sck_i,
   input  wire logic       cs_n_i,
   input  wire logic       hold_n_i,
   input  wire logic       si_i,
   output logic            so_o,
   output logic            so_oe_o,
   output logic            selected_o,
   output logic            standby_o,
   output logic            store_pulse_o,
   output logic      [1:0] mode_o
);
   ssp_pkg::ssp_state_t state, next_state;
   logic [3:0]                  bits, next_bits;
   logic [15:0]                 sh, next_sh;
   logic [ssp_pkg::ADDR_W-1:0]  addr, next_addr;
   logic                        is_rd, next_is_rd;
   logic [7:0]                  status, next_status;
   logic                        store_tgl, next_store_tgl;
   logic                        stat_tgl, next_stat_tgl;
   logic                        mem_we;
   logic                        byte_end;
   logic [7:0]                  mem [0:ssp_pkg::MEM_WORDS-1];
   logic [7:0]                  rd_byte;
   logic [7:0]                  stat_rd;
   logic                        so_q, next_so;
   logic                        drive_q, next_drive;
   logic                        link_rst_n;
   logic [ssp_pkg::SYNC_W-1:0]  synced;

   ssp_cdc_if cdc ();

   // next address after a byte, per access mode
   function automatic logic [ssp_pkg::ADDR_W-1:0] step_addr(
      input logic [ssp_pkg::ADDR_W-1:0] a,
      input logic [7:0]                 s
   );
      logic [ssp_pkg::ADDR_W-1:0] r;
      r = a;
      if (s[ssp_pkg::MODE_LSB +: 2] == ssp_pkg::MODE_PAGE) begin
         r[ssp_pkg::PAGE_W-1:0] = a[ssp_pkg::PAGE_W-1:0] + 5'h01;
      end else if (s[ssp_pkg::MODE_LSB +: 2] == ssp_pkg::MODE_BURST) begin
         r = a + 13'h0001;
      end
      return r;
   endfunction

   // true when the mode field asks for single-word access
   function automatic logic word_mode(input logic [7:0] s);
      logic r;
      r = (s[ssp_pkg::MODE_LSB +: 2] != ssp_pkg::MODE_PAGE) &&
          (s[ssp_pkg::MODE_LSB +: 2] != ssp_pkg::MODE_BURST);
      return r;
   endfunction

   // readable status: mode, option bit, type bit fixed at one, rest zero
   function automatic logic [7:0] stat_view(input logic [7:0] s);
      logic [7:0] r;
      r                     = 8'h00;
      r[ssp_pkg::MODE_LSB +: 2] = s[ssp_pkg::MODE_LSB +: 2];
      r[ssp_pkg::OPT_BIT]   = s[ssp_pkg::OPT_BIT];
      r[ssp_pkg::TYPE_BIT]  = 1'b1;
      return r;
   endfunction

   // high select clears the sequence state at once
   assign link_rst_n = arst_n_i & ~cs_n_i;

   // ---- rising edge: capture and command sequencing
   always_comb begin
      next_state     = state;
      next_bits      = bits;
      next_sh        = sh;
      next_addr      = addr;
      next_is_rd     = is_rd;
      next_status    = status;
      next_store_tgl = store_tgl;
      next_stat_tgl  = stat_tgl;
      mem_we         = 1'b0;
      byte_end       = (bits[2:0] == ssp_pkg::BYTE_LAST);
      // low pause ignores input and clock, keeping all sequence state
      if (hold_n_i && (state != ssp_pkg::ST_DONE)) begin
         next_sh   = {sh[14:0], si_i};
         next_bits = 4'(bits + 4'h1);
         unique case (state)
            ssp_pkg::ST_CMD: begin
               if (byte_end) begin
                  next_bits = 4'h0;
                  case (next_sh[7:0])
                     ssp_pkg::OP_READ: begin
                        next_state = ssp_pkg::ST_ADDR;
                        next_is_rd = 1'b1;
                     end
                     ssp_pkg::OP_WRITE: begin
                        next_state = ssp_pkg::ST_ADDR;
                        next_is_rd = 1'b0;
                     end
                     ssp_pkg::OP_STAT_RD: begin
                        next_state = ssp_pkg::ST_SRD;
                     end
                     ssp_pkg::OP_STAT_WR: begin
                        next_state = ssp_pkg::ST_SWR;
                     end
                     default: begin
                        next_state = ssp_pkg::ST_DONE;
                     end
                  endcase
               end
            end
            ssp_pkg::ST_ADDR: begin
               if (bits == ssp_pkg::ADDR_LAST) begin
                  // top three address bits are don't care
                  next_addr  = next_sh[ssp_pkg::ADDR_W-1:0];
                  next_state = is_rd ? ssp_pkg::ST_RDATA : ssp_pkg::ST_WDATA;
               end
            end
            ssp_pkg::ST_RDATA: begin
               if (byte_end) begin
                  next_addr = step_addr(addr, status);
                  if (word_mode(status)) begin
                     next_state = ssp_pkg::ST_DONE;
                  end
               end
            end
            ssp_pkg::ST_WDATA: begin
               if (byte_end) begin
                  mem_we         = 1'b1;
                  next_store_tgl = ~store_tgl;
                  next_addr      = step_addr(addr, status);
                  if (word_mode(status)) begin
                     next_state = ssp_pkg::ST_DONE;
                  end
               end
            end
            ssp_pkg::ST_SRD: begin
               if (byte_end) begin
                  next_state = ssp_pkg::ST_DONE;
               end
            end
            ssp_pkg::ST_SWR: begin
               if (byte_end) begin
                  next_status   = stat_view(next_sh[7:0]);
                  next_stat_tgl = ~stat_tgl;
                  next_state    = ssp_pkg::ST_DONE;
               end
            end
            ssp_pkg::ST_DONE: begin
               next_state = ssp_pkg::ST_DONE;
            end
         endcase
      end
   end

   always_ff @(posedge sck_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         state <= ssp_pkg::ST_CMD;
         bits  <= 4'h0;
         sh    <= 16'h0000;
         addr  <= 13'h0000;
         is_rd <= 1'b0;
      end else begin
         state <= next_state;
         bits  <= next_bits;
         sh    <= next_sh;
         addr  <= next_addr;
         is_rd <= next_is_rd;
      end
   end

   // status and event toggles outlive the frame
   always_ff @(posedge sck_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         status    <= ssp_pkg::STAT_RST;
         store_tgl <= 1'b0;
         stat_tgl  <= 1'b0;
      end else begin
         status    <= next_status;
         store_tgl <= next_store_tgl;
         stat_tgl  <= next_stat_tgl;
      end
   end

   // the byte lands on the same edge as its last bit, so no store is left open
   always_ff @(posedge sck_i) begin
      if (mem_we) begin
         mem[addr] <= next_sh[7:0];
      end
   end

   assign rd_byte = mem[addr];
   assign stat_rd = stat_view(status);

   // ---- falling edge: serial output, msb first
   always_comb begin
      next_so    = 1'b0;
      next_drive = 1'b0;
      unique case (state)
         ssp_pkg::ST_RDATA: begin
            next_so    = rd_byte[3'(ssp_pkg::BYTE_LAST - bits[2:0])];
            next_drive = 1'b1;
         end
         ssp_pkg::ST_SRD: begin
            next_so    = stat_rd[3'(ssp_pkg::BYTE_LAST - bits[2:0])];
            next_drive = 1'b1;
         end
         ssp_pkg::ST_CMD, ssp_pkg::ST_ADDR, ssp_pkg::ST_WDATA,
         ssp_pkg::ST_SWR, ssp_pkg::ST_DONE: begin
            next_so    = 1'b0;
            next_drive = 1'b0;
         end
      endcase
   end

   // frozen state gives the same bit again, so a paused edge changes nothing
   always_ff @(negedge sck_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         so_q    <= 1'b0;
         drive_q <= 1'b0;
      end else begin
         so_q    <= next_so;
         drive_q <= next_drive;
      end
   end

   assign so_o = so_q;
   // pause releases and restores the pin without waiting for a clock edge
   assign so_oe_o = drive_q & hold_n_i;

   // ---- crossing to the system clock
   assign cdc.sel       = ~cs_n_i;
   assign cdc.store_tgl = store_tgl;
   assign cdc.stat_tgl  = stat_tgl;
   assign cdc.status    = status;

   ssp_sync #(
      .W (ssp_pkg::SYNC_W)
   ) u_sync (
      .clock_i  (clock_i),
      .arst_n_i (arst_n_i),
      .ce_i     (ce_i),
      .d_i      ({cdc.stat_tgl, cdc.store_tgl, cdc.sel}),
      .q_o      (synced)
   );

   ssp_sys_side u_sys (
      .clock_i       (clock_i),
      .arst_n_i      (arst_n_i),
      .ce_i          (ce_i),
      .synced_i      (synced),
      .cdc           (cdc),
      .selected_o    (selected_o),
      .standby_o     (standby_o),
      .store_pulse_o (store_pulse_o),
      .mode_o        (mode_o)
   );
endmodule

/* sim/ssp_chk.sv */
// concurrent checks on the serial memory slave pins and system-side view
module ssp_chk (
   input wire logic       clock_i,
   input wire logic       arst_n_i,
   input wire logic       ce_i,
   input wire logic       sck_i,
   input wire logic       cs_n_i,
   input wire logic       hold_n_i,
   input wire logic       so_o,
   input wire logic       so_oe_o,
   input wire logic       selected_o,
   input wire logic       standby_o,
   input wire logic       store_pulse_o,
   input wire logic [1:0] mode_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_i); endclocking
   // a low enable freezes the system-side view, so its timing checks rest then
   default disable iff (!arst_n_i || !ce_i);
   sequence sel_fall;
      $fell(cs_n_i);
   endsequence
   sequence sel_rise;
      $rose(cs_n_i);
   endsequence
   sequence out_on;
      $rose(so_oe_o);
   endsequence
   idle_release_a: assert property (cs_n_i |-> !so_oe_o)
      else $error("output driven while deselected");
   pause_release_a: assert property (!hold_n_i |-> !so_oe_o)
      else $error("output driven during pause");
   out_edge_a: assert property ((so_oe_o && $changed(so_o)) |-> !sck_i)
      else $error("output changed with serial clock high");
   out_start_a: assert property (out_on |-> !sck_i && hold_n_i && !cs_n_i)
      else $error("output enabled at wrong moment");
   sel_follow_a: assert property (sel_fall |-> ##[2:4] selected_o)
      else $error("selection not seen in time");
   desel_follow_a: assert property (sel_rise |-> ##[2:4] !selected_o)
      else $error("deselection not seen in time");
   standby_idle_a: assert property (selected_o |-> !standby_o)
      else $error("standby while selected");
   standby_back_a: assert property (sel_rise |-> ##[2:12] standby_o)
      else $error("standby not entered after deselect");
   store_once_a: assert property (store_pulse_o |=> !store_pulse_o)
      else $error("store pulse longer than one cycle");
   reset_state_a: assert property (disable iff (1'b0) !arst_n_i |-> standby_o &&
      !selected_o && !so_oe_o && mode_o == 2'h0 && !store_pulse_o)
      else $error("wrong state during reset");
endmodule
bind ssp_top ssp_chk i_ssp_chk (.clock_i, .arst_n_i, .ce_i, .sck_i, .cs_n_i, .hold_n_i, .so_o,
   .so_oe_o, .selected_o, .standby_o, .store_pulse_o, .mode_o);

/* sim/ssp_host_model.sv */
// host serial controller model driving the memory slave pins
module ssp_host_model (
   output logic      sck_o,
   output logic      cs_n_o,
   output logic      hold_n_o,
   output logic      si_o,
   input  wire logic so_i,
   input  wire logic so_oe_i
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam time HALF = 40ns;
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b0;
      hold_n_o = 1'b1;
      si_o = 1'b0;
      #2;
      cs_n_o = 1'b1;
   end
   task automatic open_frame;
      #3;
      cs_n_o = 1'b0;
      #HALF;
   endtask
   task automatic close_frame;
      #HALF;
      cs_n_o = 1'b1;
      si_o = ~si_o;
      #(2 * HALF);
   endtask
   // hb names the bit before which a pause is inserted, -1 for none
   task automatic xfer(input logic [7:0] tx, input int hb, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         if (i == hb) begin
            hold_n_o = 1'b0;
            #HALF;
            si_o = ~tx[i];
            sck_o = 1'b1;
            #HALF;
            sck_o = 1'b0;
            #HALF;
            hold_n_o = 1'b1;
         end
         si_o = tx[i];
         #HALF;
         sck_o = 1'b1;
         // a released line reads as z so it can never match data
         rx[i] = so_oe_i ? so_i : 1'bz;
         #HALF;
         sck_o = 1'b0;
      end
   endtask
endmodule

/* sim/ssp_top_tb.sv */
// self-checking bench for the serial memory slave with a host model
module ssp_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clock_i;
   logic       arst_n_i;
   logic       ce_i;
   logic       sck;
   logic       cs_n;
   logic       hold_n;
   logic       si;
   logic       so;
   logic       so_oe;
   logic       selected;
   logic       standby;
   logic       store_pulse;
   logic [1:0] mode;
   int         num_errors = 0;
   int         samples_checked = 0;
   int         n_store = 0;
   logic [7:0] wq[$];
   logic [7:0] rq[$];
   logic [7:0] rx;

   ssp_top i_ssp_top (.clock_i(clock_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .sck_i(sck),
      .cs_n_i(cs_n), .hold_n_i(hold_n), .si_i(si), .so_o(so), .so_oe_o(so_oe),
      .selected_o(selected), .standby_o(standby), .store_pulse_o(store_pulse), .mode_o(mode));
   ssp_host_model i_ssp_host_model (.sck_o(sck), .cs_n_o(cs_n), .hold_n_o(hold_n), .si_o(si),
      .so_i(so), .so_oe_i(so_oe));

   initial clock_i = 1'b0;
   always #5 clock_i = ~clock_i;
   always @(posedge clock_i) if (store_pulse === 1'b1) n_store++;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic stat_frame(input logic [7:0] op, input logic [7:0] val);
      i_ssp_host_model.open_frame();
      i_ssp_host_model.xfer(op, -1, rx);
      i_ssp_host_model.xfer(val, -1, rx);
      i_ssp_host_model.close_frame();
      repeat (8) @(posedge clock_i);
   endtask
   task automatic mem_frame(input logic [7:0] op, input logic [15:0] a, input int n,
                            input int hb);
      rq.delete();
      i_ssp_host_model.open_frame();
      i_ssp_host_model.xfer(op, -1, rx);
      i_ssp_host_model.xfer(a[15:8], -1, rx);
      i_ssp_host_model.xfer(a[7:0], -1, rx);
      for (int k = 0; k < n; k++) begin
         i_ssp_host_model.xfer((k < wq.size()) ? wq[k] : 8'h00, (k == 1) ? hb : -1, rx);
         rq.push_back(rx);
      end
      i_ssp_host_model.close_frame();
      repeat (8) @(posedge clock_i);
   endtask
   task automatic t_status;
      logic [7:0] vals[3];
      logic [1:0] modes[3];
      vals = '{8'h40, 8'h80, 8'h00};
      modes = '{ssp_pkg::MODE_BURST, ssp_pkg::MODE_PAGE, ssp_pkg::MODE_WORD};
      for (int k = 0; k < 3; k++) begin
         stat_frame(ssp_pkg::OP_STAT_WR, vals[k]);
         chk({6'h00, mode}, {6'h00, modes[k]}, "mode after status write");
         stat_frame(ssp_pkg::OP_STAT_RD, 8'h00);
         chk(rx, vals[k] | 8'h02, "status readback");
      end
      $display("test status done");
   endtask
   task automatic t_burst;
      int n0;
      stat_frame(ssp_pkg::OP_STAT_WR, 8'h40);
      wq = '{8'ha1, 8'hb2, 8'hc3};
      n0 = n_store;
      mem_frame(ssp_pkg::OP_WRITE, 16'hfffe, 3, -1);
      chk(8'(n_store - n0), 8'h03, "burst store count");
      wq.delete();
      // pause inside the second byte; clocks during it must be ignored
      mem_frame(ssp_pkg::OP_READ, 16'h1ffe, 3, 4);
      chk(rq[0], 8'ha1, "burst byte 0");
      chk(rq[1], 8'hb2, "burst byte 1 across pause");
      chk(rq[2], 8'hc3, "burst byte 2 after wrap");
      $display("test burst done");
   endtask
   task automatic t_page;
      int n0;
      stat_frame(ssp_pkg::OP_STAT_WR, 8'h80);
      wq = '{8'h5a, 8'h3c, 8'h96};
      mem_frame(ssp_pkg::OP_WRITE, 16'h011e, 3, -1);
      wq.delete();
      mem_frame(ssp_pkg::OP_READ, 16'h011f, 2, -1);
      chk(rq[0], 8'h3c, "page last word");
      chk(rq[1], 8'h96, "page wrap to word zero");
      stat_frame(ssp_pkg::OP_STAT_WR, 8'h00);
      mem_frame(ssp_pkg::OP_READ, 16'h0000, 1, -1);
      chk(rq[0], 8'hc3, "burst wrap landed at zero");
      mem_frame(ssp_pkg::OP_READ, 16'h0100, 2, -1);
      chk(rq[0], 8'h96, "word read");
      chk(rq[1], 8'hzz, "word mode stops after one byte");
      n0 = n_store;
      wq = '{8'h11, 8'h22};
      mem_frame(ssp_pkg::OP_WRITE, 16'h0100, 2, -1);
      mem_frame(8'h0b, 16'h0100, 1, -1);
      chk(rq[0], 8'hzz, "unknown opcode stays silent");
      chk(8'(n_store - n0), 8'h01, "word write stores one byte");
      wq.delete();
      mem_frame(ssp_pkg::OP_READ, 16'h0100, 1, -1);
      chk(rq[0], 8'h11, "word write data");
      $display("test page and word done");
   endtask
   task automatic t_enable;
      @(negedge clock_i);
      ce_i = 1'b0;
      stat_frame(ssp_pkg::OP_STAT_WR, 8'h80);
      chk({6'h00, mode}, {6'h00, ssp_pkg::MODE_WORD}, "mode frozen while disabled");
      @(negedge clock_i);
      ce_i = 1'b1;
      repeat (8) @(posedge clock_i);
      chk({6'h00, mode}, {6'h00, ssp_pkg::MODE_PAGE}, "mode after enable");
      $display("test enable done");
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   initial begin
      arst_n_i = 1'b1;
      ce_i = 1'b1;
      // reset falls after time zero so every asynchronously reset flop sees it
      #1;
      arst_n_i = 1'b0;
      repeat (3) @(negedge clock_i);
      chk({3'h0, standby, selected, so_oe, mode}, 8'h10, "reset state");
      arst_n_i = 1'b1;
      $display("test reset done");
      repeat (4) @(negedge clock_i);
      t_status();
      t_burst();
      t_page();
      t_enable();
      give_verdict();
   end
   initial begin
      #500us;
      num_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      give_verdict();
   end
endmodule
